// >>> bench/pmt_pwm_partner.sv
module pmt_pwm_partner
   import pmt_pkg::*;
#(
   parameter int N_PWM = 2
)
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   output logic      [2*N_PWM-1:0] other_timer_match
);
   logic [3:0] phase_reg;
   // Other timers match at only two rates, phase_reg[0] and phase_reg[1], repeated for each module
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= 4'h0;
      end else begin
         phase_reg <= phase_reg + 4'h1;
      end
   end
   assign other_timer_match = {N_PWM{phase_reg[1:0]}};
endmodule

// >>> bench/pmt_timer_props.sv
module pmt_timer_props
   import pmt_pkg::*;
#(
   parameter int N_PWM = 2
)
(
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [7:0]         paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               sleep,
   input wire logic [3:0]         serial_port_mode,
   input wire logic [2*N_PWM-1:0] other_timer_match,
   input wire logic               timer_match,
   input wire logic [N_PWM-1:0]   pwm_timebase,
   input wire logic               spi_shift_clk,
   input wire logic               irq,
   input wire logic               irq_priority
);
   // Write taken at this edge; any write may legally move the outputs
   wire wr = psel && penable && pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_READY: assert property (psel && penable |-> pready)
      else $error("no ready in access phase");
   AST_IDLE_BUS: assert property (!(psel && penable) |-> prdata == 32'h0 && !pslverr)
      else $error("read bus busy while idle");
   AST_UNMAPPED: assert property (psel && penable && paddr > PMT_OFF_SYSCTL |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   AST_SPI_CLK: assert property (spi_shift_clk == (timer_match && serial_port_mode == PMT_SPI_TMR_MODE))
      else $error("shift clock routing wrong");
   AST_IRQ_STICKY: assert property (irq && !wr |=> irq)
      else $error("flag dropped without write");
   AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(timer_match) || $past(wr))
      else $error("flag set without match");
   AST_SLEEP_HOLD: assert property (sleep && !wr |=> $stable(timer_match))
      else $error("timer moved in sleep");
   AST_TICK_GAP: assert property (!wr ##1 $fell(timer_match) && !wr ##1 !wr |=> !timer_match)
      else $error("ticks closer than four clocks");
endmodule

bind pmt_timer pmt_timer_props #(.N_PWM(N_PWM)) pmt_timer_props_i (.*);

// >>> bench/pmt_timer_tb_top.sv
module pmt_timer_tb_top
   import pmt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, sleep, se;
   logic        pready, pslverr, timer_match, spi_shift_clk, irq, irq_priority;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  serial_port_mode, other_timer_match;
   logic [1:0]  pwm_timebase;
   int          err_total, checked;
   pmt_timer #(.N_PWM(2)) pmt_timer_i (.*);
   pmt_pwm_partner #(.N_PWM(2)) pmt_pwm_partner_i (.*);
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // Whole run is under two thousand cycles
   initial begin
      #400000;
      err_total++;
      print_verdict();
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; request held until pready seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask
   // Cycles until k rising edges of the match output
   task automatic rises(input int k, output int n);
      logic last;
      n = 0;
      last = timer_match;
      while (k > 0) begin
         @(posedge pclk);
         n++;
         if (timer_match && !last) k--;
         last = timer_match;
      end
   endtask
   task automatic t_reset();
      rdchk(PMT_OFF_COUNT, 32'h0, "count");
      rdchk(PMT_OFF_PERIOD, 32'hFF, "period");
      rdchk(PMT_OFF_CONTROL, 32'h0, "control");
      apb(1'b1, 8'h40, 32'h1);
      chk(se, 1'b1, "unmapped error");
   endtask
   // Period 3 gives four ticks per match at every divide
   task automatic t_prescale();
      int n;
      logic [31:0] gap [4] = '{32'd16, 32'd64, 32'd256, 32'd256};
      apb(1'b1, PMT_OFF_PERIOD, 32'h3);
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, PMT_OFF_CONTROL, 32'h4 | 32'(p));
         rises(1, n);
         rises(1, n);
         chk(n, gap[p], "match gap");
      end
   endtask
   task automatic t_post();
      int n;
      logic last;
      apb(1'b1, PMT_OFF_MASK, 32'h1);
      apb(1'b1, PMT_OFF_PERIOD, 32'h1);
      for (int s = 0; s < 16; s += 5) begin
         apb(1'b1, PMT_OFF_CONTROL, 32'h0);
         apb(1'b1, PMT_OFF_STATUS, 32'h1);
         apb(1'b1, PMT_OFF_COUNT, 32'h0);
         apb(1'b1, PMT_OFF_CONTROL, 32'(4 | (s << 3)));
         n = 0;
         last = timer_match;
         for (int c = 0; c < 3000 && irq !== 1'b1; c++) begin
            @(posedge pclk);
            if (timer_match && !last) n++;
            last = timer_match;
         end
         chk(n, 32'(s + 1), "matches per flag");
      end
      apb(1'b1, PMT_OFF_CONTROL, 32'h0);
      apb(1'b1, PMT_OFF_MASK, 32'h0);
      @(posedge pclk);
      chk(irq, 1'b0, "masked irq");
      apb(1'b1, PMT_OFF_MASK, 32'h1);
      @(posedge pclk);
      chk(irq, 1'b1, "sticky flag");
      apb(1'b1, PMT_OFF_STATUS, 32'h1);
      @(posedge pclk);
      chk(irq, 1'b0, "cleared flag");
   endtask
   // Timer off: count write, then control write, count must survive
   task automatic t_hold();
      apb(1'b1, PMT_OFF_COUNT, 32'h22);
      apb(1'b1, PMT_OFF_CONTROL, 32'h1);
      repeat (40) @(posedge pclk);
      rdchk(PMT_OFF_COUNT, 32'h22, "held count");
      sleep <= 1'b1;
      apb(1'b1, PMT_OFF_CONTROL, 32'h4);
      repeat (40) @(posedge pclk);
      rdchk(PMT_OFF_COUNT, 32'h22, "sleep count");
      rdchk(PMT_OFF_PERIOD, 32'h1, "sleep period");
      sleep <= 1'b0;
   endtask
   task automatic t_sys();
      apb(1'b1, PMT_OFF_SYSCTL, 32'h2);
      apb(1'b1, PMT_OFF_PERIOD, 32'h7);
      rdchk(PMT_OFF_PERIOD, 32'hFF, "disabled period");
      rdchk(PMT_OFF_COUNT, 32'h0, "disabled count");
      apb(1'b1, PMT_OFF_SYSCTL, 32'h5);
      @(posedge pclk);
      chk(irq_priority, 1'b1, "priority");
      repeat (4) begin
         @(posedge pclk);
         chk(pwm_timebase[0], other_timer_match[0], "pwm0 base");
         chk(pwm_timebase[1], timer_match, "pwm1 base");
      end
   endtask
   // Shift clock only in its serial mode; then a second reset in mid-run
   task automatic t_spi();
      int n;
      apb(1'b1, PMT_OFF_PERIOD, 32'h3);
      apb(1'b1, PMT_OFF_CONTROL, 32'h4);
      serial_port_mode <= 4'h0;
      rises(1, n);
      chk(spi_shift_clk, 1'b0, "shift clock off");
      chk(pwm_timebase[1], 1'b1, "pwm1 own match");
      serial_port_mode <= 4'h3;
      rises(1, n);
      chk(spi_shift_clk, 1'b1, "shift clock on");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(PMT_OFF_PERIOD, 32'hFF, "period after reset");
      rdchk(PMT_OFF_COUNT, 32'h0, "count after reset");
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sleep = 1'b0;
      serial_port_mode = 4'h3;
      err_total = 0;
      checked = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_prescale();
      t_post();
      t_hold();
      t_sys();
      t_spi();
      print_verdict();
   end
endmodule

// >>> verilog/pmt_pkg.sv
package pmt_pkg;

   // Register byte offsets on APB
   localparam logic [7:0] PMT_OFF_COUNT   = 8'h00;
   localparam logic [7:0] PMT_OFF_PERIOD  = 8'h04;
   localparam logic [7:0] PMT_OFF_CONTROL = 8'h08;
   localparam logic [7:0] PMT_OFF_STATUS  = 8'h0C;
   localparam logic [7:0] PMT_OFF_MASK    = 8'h10;
   localparam logic [7:0] PMT_OFF_SYSCTL  = 8'h14;

   // Control register fields
   localparam int PMT_CTL_PRE_LSB  = 0;   // prescale_select [1:0]
   localparam int PMT_CTL_ON_BIT   = 2;   // timer on
   localparam int PMT_CTL_POST_LSB = 3;   // postscale_select [6:3]

   // System control register fields
   localparam int PMT_SYS_PRIO_BIT = 0;   // match_irq_priority
   localparam int PMT_SYS_DIS_BIT  = 1;   // timer_module_disable
   localparam int PMT_SYS_SEL_LSB  = 2;   // pwm_timebase_select pairs from here

   // Reset values
   localparam logic [7:0] PMT_COUNT_RST  = 8'h00;
   localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;
   localparam logic [6:0] PMT_CTL_RST    = 7'h00;

   // Instruction clock divides the core clock by four
   localparam int         PMT_ICLK_DIV   = 4;

   // Serial port mode that selects this timer as shift clock
   localparam logic [3:0] PMT_SPI_TMR_MODE = 4'h3;

   typedef enum logic [1:0] {
      PMT_PRE_DIV1,
      PMT_PRE_DIV4,
      PMT_PRE_DIV16A,
      PMT_PRE_DIV16B
   } pmt_pre_t;

endpackage

// >>> verilog/pmt_prescaler.sv
module pmt_prescaler
   import pmt_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       clear,
   input  wire logic       tick_in,
   input  wire logic [1:0] prescale_select,
   output logic            tick_out
);

   logic [3:0] pre_cnt_reg;
   logic [3:0] pre_cnt_next;
   logic [3:0] pre_limit;
   logic       pre_wrap;

   // Divide ratio decode: 1, 4 or 16
   assign pre_limit = (prescale_select == PMT_PRE_DIV1) ? 4'h0 :
                      (prescale_select == PMT_PRE_DIV4) ? 4'h3 : 4'hF;
   assign pre_wrap  = (pre_cnt_reg >= pre_limit);
   assign tick_out  = tick_in && pre_wrap;
   assign pre_cnt_next = clear ? 4'h0 :
                         (tick_in ? (pre_wrap ? 4'h0 : pre_cnt_reg + 4'h1) : pre_cnt_reg);

   // Four-bit prescale counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_reg <= 4'h0;
      end else begin
         pre_cnt_reg <= pre_cnt_next;
      end
   end

endmodule

// >>> verilog/pmt_timer.sv
module pmt_timer
   import pmt_pkg::*;
#(
   parameter int N_PWM = 2
)
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               sleep,
   input  wire logic [3:0]         serial_port_mode,
   input  wire logic [2*N_PWM-1:0] other_timer_match,
   output logic                    timer_match,
   output logic      [N_PWM-1:0]   pwm_timebase,
   output logic                    spi_shift_clk,
   output logic                    irq,
   output logic                    irq_priority
);

   initial begin
      if (N_PWM < 1 || N_PWM > 15) begin
         $error("N_PWM out of range");
      end
   end

   localparam int SYS_W = PMT_SYS_SEL_LSB + 2 * N_PWM;

   logic [7:0]       timer_count_reg;
   logic [7:0]       timer_count_next;
   logic [7:0]       period_value_reg;
   logic [6:0]       timer_control_reg;
   logic [1:0]       iclk_reg;
   logic [3:0]       post_cnt_reg;
   logic [3:0]       post_cnt_next;
   logic             match_irq_flag_reg;
   logic             match_irq_enable_reg;
   logic [SYS_W-1:0] sysctl_reg;
   logic             wr_en;
   logic             rd_en;
   logic             wr_count;
   logic             wr_period;
   logic             wr_control;
   logic             wr_status;
   logic             wr_mask;
   logic             wr_sysctl;
   logic             addr_ok;
   logic             mod_dis;
   logic             timer_on;
   logic             iclk_tick;
   logic             run_tick;
   logic             pre_tick;
   logic             scaler_clr;
   logic             post_hit;
   logic [1:0]       prescale_select;
   logic [3:0]       postscale_select;
   logic [31:0]      rd_mux;

   // APB decode; zero wait states so pready is always high
   assign wr_en      = psel && penable && pwrite;
   assign rd_en      = psel && penable && !pwrite;
   assign wr_count   = wr_en && (paddr == PMT_OFF_COUNT);
   assign wr_period  = wr_en && (paddr == PMT_OFF_PERIOD);
   assign wr_control = wr_en && (paddr == PMT_OFF_CONTROL);
   assign wr_status  = wr_en && (paddr == PMT_OFF_STATUS);
   assign wr_mask    = wr_en && (paddr == PMT_OFF_MASK);
   assign wr_sysctl  = wr_en && (paddr == PMT_OFF_SYSCTL);
   assign addr_ok    = (paddr == PMT_OFF_COUNT) || (paddr == PMT_OFF_PERIOD) ||
                       (paddr == PMT_OFF_CONTROL) || (paddr == PMT_OFF_STATUS) ||
                       (paddr == PMT_OFF_MASK) || (paddr == PMT_OFF_SYSCTL);
   assign pready     = 1'b1;
   assign pslverr    = psel && penable && !addr_ok;

   // Control field breakout
   assign prescale_select  = timer_control_reg[PMT_CTL_PRE_LSB +: 2];
   assign postscale_select = timer_control_reg[PMT_CTL_POST_LSB +: 4];
   assign timer_on         = timer_control_reg[PMT_CTL_ON_BIT];
   assign mod_dis          = sysctl_reg[PMT_SYS_DIS_BIT];

   // Instruction clock tick, one pclk in four
   assign iclk_tick = (iclk_reg == 2'(PMT_ICLK_DIV - 1));
   // Sleep and timer-off freeze the time base; disable also clears prescaler and count
   assign run_tick  = iclk_tick && timer_on && !sleep && !mod_dis;
   assign scaler_clr = wr_count || wr_control || mod_dis;

   // Comparator runs every cycle
   assign timer_match = !mod_dis && (timer_count_reg == period_value_reg);

   pmt_prescaler u_pre (
      .pclk            (pclk),
      .presetn         (presetn),
      .clear           (scaler_clr),
      .tick_in         (run_tick),
      .prescale_select (prescale_select),
      .tick_out        (pre_tick)
   );

   // Count: disable wins, then write, then match reset, then increment
   assign timer_count_next = mod_dis   ? PMT_COUNT_RST :
                             wr_count  ? pwdata[7:0] :
                             !pre_tick ? timer_count_reg :
                             timer_match ? PMT_COUNT_RST :
                             timer_count_reg + 8'h01;

   // Postscaler advances on each counted match
   assign post_hit      = pre_tick && timer_match && (post_cnt_reg == postscale_select);
   assign post_cnt_next = scaler_clr ? 4'h0 :
                          !(pre_tick && timer_match) ? post_cnt_reg :
                          post_hit ? 4'h0 : post_cnt_reg + 4'h1;

   // Instruction clock divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iclk_reg <= 2'h0;
      end else begin
         iclk_reg <= iclk_reg + 2'h1;
      end
   end

   // Counter state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_count_reg <= PMT_COUNT_RST;
         post_cnt_reg    <= 4'h0;
      end else begin
         timer_count_reg <= timer_count_next;
         post_cnt_reg    <= post_cnt_next;
      end
   end

   // Period and control; disable forces them to reset values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period_value_reg  <= PMT_PERIOD_RST;
         timer_control_reg <= PMT_CTL_RST;
      end else if (mod_dis) begin
         period_value_reg  <= PMT_PERIOD_RST;
         timer_control_reg <= PMT_CTL_RST;
      end else begin
         if (wr_period) begin
            period_value_reg <= pwdata[7:0];
         end
         if (wr_control) begin
            timer_control_reg <= pwdata[6:0];
         end
      end
   end

   // Sticky flag: a new event beats a same-cycle clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_irq_flag_reg <= 1'b0;
      end else if (post_hit) begin
         match_irq_flag_reg <= 1'b1;
      end else if (mod_dis || (wr_status && pwdata[0])) begin
         match_irq_flag_reg <= 1'b0;
      end
   end

   // Mask and system control live outside the disabled module
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_irq_enable_reg <= 1'b0;
         sysctl_reg           <= '0;
      end else begin
         if (wr_mask) begin
            match_irq_enable_reg <= pwdata[0];
         end
         if (wr_sysctl) begin
            sysctl_reg <= pwdata[SYS_W-1:0];
         end
      end
   end

   assign irq          = match_irq_flag_reg && match_irq_enable_reg;
   assign irq_priority = sysctl_reg[PMT_SYS_PRIO_BIT];
   assign spi_shift_clk = (serial_port_mode == PMT_SPI_TMR_MODE) && timer_match;

   // Per-module time base select: 0 is this timer, else another timer
   genvar gi;
   generate
      for (gi = 0; gi < N_PWM; gi++) begin : g_pwm
         logic [1:0] tsel;
         assign tsel = sysctl_reg[PMT_SYS_SEL_LSB + 2*gi +: 2];
         assign pwm_timebase[gi] = (tsel == 2'h0) ? timer_match :
                                   other_timer_match[2*gi + int'(tsel) - 1];
      end
   endgenerate

   // Read mux; unmapped reads give zero
   assign rd_mux = (paddr == PMT_OFF_COUNT)   ? {24'h0, timer_count_reg} :
                   (paddr == PMT_OFF_PERIOD)  ? {24'h0, period_value_reg} :
                   (paddr == PMT_OFF_CONTROL) ? {25'h0, timer_control_reg} :
                   (paddr == PMT_OFF_STATUS)  ? {31'h0, match_irq_flag_reg} :
                   (paddr == PMT_OFF_MASK)    ? {31'h0, match_irq_enable_reg} :
                   (paddr == PMT_OFF_SYSCTL)  ? 32'(sysctl_reg) : 32'h0;
   assign prdata = rd_en ? rd_mux : 32'h0;

endmodule
